// ==== design/pair_shutdown_drive.sv ====
// One output pair's drive under shutdown.
// Assumes caller gives the polarity bits as inactive level, and the dead-band flag.
`timescale 1ns/1ps
module pair_shutdown_drive (
   // Configuration
   input wire logic [1:0] level_sel_i,
   input wire logic [1:0] inactive_lvl_i,
   input wire logic deadband_done_i,
   // Normal drive
   input wire logic [1:0] norm_data_i,
   input wire logic shut_i,
   // Result
   output logic [1:0] data_o,
   output logic [1:0] oe_o
);
   always_comb begin
      data_o = norm_data_i;
      oe_o = 2'h3;
      if (shut_i) begin
         case (shutdown_pkg::pair_level_t'(level_sel_i))
            shutdown_pkg::LEVEL_HIGH: data_o = 2'h3;
            shutdown_pkg::LEVEL_LOW: data_o = 2'h0;
            shutdown_pkg::LEVEL_FLOAT: begin
               data_o = 2'h0;
               oe_o = 2'h0;
            end
            default: begin
               // Keep normal drive until dead band has passed
               if (deadband_done_i) begin
                  data_o = inactive_lvl_i;
               end
            end
         endcase
      end
   end
endmodule

// ==== design/shutdown_pkg.sv ====
// Package for the waveform auto-shutdown block.
// Assumes a single clock domain and the plain register port.
package shutdown_pkg;
   // Register map (byte offsets on the plain port)
   localparam logic [3:0] CTRL_OFFS = 4'h0;
   localparam logic [3:0] SRC_EN_OFFS = 4'h1;
   localparam logic [3:0] INT_STATUS_OFFS = 4'h2;
   localparam logic [3:0] INT_MASK_OFFS = 4'h3;
   localparam logic [3:0] DEADBAND_OFFS = 4'h4;

   // Control field positions
   localparam int CTRL_SHUTDOWN_BIT = 7;
   localparam int CTRL_RESTART_BIT = 6;
   localparam int CTRL_BD_LSB = 4;
   localparam int CTRL_AC_LSB = 2;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h14;
   localparam logic [7:0] SRC_EN_RESET = 8'h00;
   localparam logic [5:0] DEADBAND_RESET = 6'h00;
   localparam logic [1:0] INT_RESET = 2'h0;

   // Readback masks for unimplemented bits
   localparam logic [7:0] CTRL_READ_MASK = 8'hFC;
   localparam logic [7:0] SRC_EN_READ_MASK = 8'h1F;

   // Interrupt status bit positions
   localparam int INT_SHUTDOWN_BIT = 0;
   localparam int INT_RESTART_BIT = 1;

   // Pair shutdown level codes
   typedef enum logic [1:0] {
      LEVEL_INACTIVE = 2'h0,
      LEVEL_FLOAT = 2'h1,
      LEVEL_LOW = 2'h2,
      LEVEL_HIGH = 2'h3
   } pair_level_t;

   typedef struct packed {
      logic logic_cell_two_output;
      logic comparator_two_output;
      logic comparator_one_output;
      logic timer_postscale_output;
      logic input_pin_output;
   } shutdown_src_t;

   typedef struct packed {
      logic [3:0] data;
      logic [3:0] oe;
   } out_pins_t;
endpackage

// ==== design/waveform_auto_shutdown.sv ====
// Auto-shutdown control of a four-output complementary waveform generator.
// Assumes shutdown sources and input waveform are asynchronous to clk_i,
// and that normal drive and polarity come from same-clock generator logic.
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps

// Function
// [RQ1] Status flag reads one while shutdown holds outputs, else zero; code reads zero in WAIT_EDGE_ST though outputs stay held.
// [RQ2] Any enabled source asserting sets the status flag; sources ORed.
// [RQ3] Software write of one to flag forces shutdown, even while disabled.
// [RQ4] After clear, shutdown levels stay until next input rising edge.
// [RQ5] Restart enabled clears automatically when source ends; else software clears.
// [RQ6] B/D shutdown field: 11 high, 10 low, 01 high impedance.
// [RQ7] A/C shutdown field: 11 high, 10 low, 01 high impedance.
// [RQ8] Field 00 drives inactive level with polarity after dead band.
// [RQ9] Logic-cell two output is a source only when its enable set.
// [RQ10] Comparator two output is a source only when its enable set.
// [RQ11] Comparator one output is a source only when its enable set.
// [RQ12] Timer postscale output is a source only when its enable set.
// [RQ13] Unimplemented source enable bits 7-5 and control bits 1-0 read zero.
module waveform_auto_shutdown (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Shutdown sources and input waveform (asynchronous)
   input wire shutdown_pkg::shutdown_src_t src_i,
   input wire logic wave_in_i,
   // Generator side: normal drive A..D and polarity A..D (same clock)
   input wire logic [3:0] norm_data_i,
   input wire logic [3:0] polarity_i,
   // Output pins A..D
   output shutdown_pkg::out_pins_t pins_o,
   // Interrupt
   output logic irq_o
);
   // Synchronisers
   logic [4:0] src_meta_reg;
   logic [4:0] src_sync_reg;
   logic [2:0] wave_sync_reg;
   logic [4:0] src_meta_next;
   logic [4:0] src_sync_next;
   logic [2:0] wave_sync_next;

   // Registers
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [4:0] src_en_reg;
   logic [4:0] src_en_next;
   logic [1:0] int_status_reg;
   logic [1:0] int_status_next;
   logic [1:0] int_mask_reg;
   logic [1:0] int_mask_next;
   logic [5:0] deadband_reg;
   logic [5:0] deadband_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;

   // Shutdown sequencing
   typedef enum logic [1:0] {
      RUN_ST,
      SHUT_ST,
      WAIT_EDGE_ST
   } shut_state_t;
   shut_state_t state_reg;
   shut_state_t state_next;
   logic [5:0] db_cnt_reg;
   logic [5:0] db_cnt_next;
   shutdown_pkg::out_pins_t pins_reg;
   shutdown_pkg::out_pins_t pins_next;

   logic source_active;
   logic wave_rise;
   logic flag_wr_one;
   logic flag_wr_zero;
   logic ctrl_wr;
   logic shut_out;
   logic db_done;
   logic [1:0] ac_data;
   logic [1:0] ac_oe;
   logic [1:0] bd_data;
   logic [1:0] bd_oe;

   always_comb begin
      src_meta_next = src_i;
      src_sync_next = src_meta_reg;
      wave_sync_next = {wave_sync_reg[1], wave_sync_reg[0], wave_in_i};
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         src_meta_reg <= 5'h00;
         src_sync_reg <= 5'h00;
         wave_sync_reg <= 3'h0;
      end else begin
         src_meta_reg <= src_meta_next;
         src_sync_reg <= src_sync_next;
         wave_sync_reg <= wave_sync_next;
      end
   end

   // Rising edge seen on the second and third stages only
   assign wave_rise = wave_sync_reg[1] & ~wave_sync_reg[2];

   // [RQ9] [RQ10] [RQ11] [RQ12] [RQ2] Gated source OR
   assign source_active = |(src_sync_reg & src_en_reg);

   assign ctrl_wr = reg_wr_i && (reg_addr_i == shutdown_pkg::CTRL_OFFS);
   assign flag_wr_one = ctrl_wr && reg_wdata_i[shutdown_pkg::CTRL_SHUTDOWN_BIT];
   assign flag_wr_zero = ctrl_wr && !reg_wdata_i[shutdown_pkg::CTRL_SHUTDOWN_BIT];

   // Shutdown state machine and control register
   always_comb begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      if (ctrl_wr) begin
         ctrl_next[6:2] = reg_wdata_i[6:2];
      end
      case (state_reg)
         RUN_ST: begin
            // [RQ3] Software forced shutdown
            if (source_active || flag_wr_one) begin
               state_next = SHUT_ST;
            end
         end
         SHUT_ST: begin
            // [RQ5] Auto or software restart; a live source wins
            if (source_active || flag_wr_one) begin
               state_next = SHUT_ST;
            end else if (ctrl_reg[shutdown_pkg::CTRL_RESTART_BIT] || flag_wr_zero) begin
               state_next = WAIT_EDGE_ST;
            end
         end
         WAIT_EDGE_ST: begin
            // [RQ4] Resume only on input rising edge
            if (source_active || flag_wr_one) begin
               state_next = SHUT_ST;
            end else if (wave_rise) begin
               state_next = RUN_ST;
            end
         end
         default: state_next = RUN_ST;
      endcase
      // [RQ1] Flag mirrors SHUT_ST only; it reads zero in WAIT_EDGE_ST while outputs stay held
      ctrl_next[shutdown_pkg::CTRL_SHUTDOWN_BIT] = (state_next == SHUT_ST);
      // [RQ13] Low control bits stay zero
      ctrl_next[1:0] = 2'h0;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= RUN_ST;
         ctrl_reg <= shutdown_pkg::CTRL_RESET;
      end else begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Dead-band timer started at shutdown entry
   always_comb begin
      db_cnt_next = db_cnt_reg;
      if (state_reg == RUN_ST) begin
         db_cnt_next = 6'h00;
      end else if (db_cnt_reg != deadband_reg) begin
         db_cnt_next = db_cnt_reg + 6'h01;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         db_cnt_reg <= 6'h00;
      end else begin
         db_cnt_reg <= db_cnt_next;
      end
   end

   assign db_done = (state_reg != RUN_ST) && (db_cnt_reg == deadband_reg);
   assign shut_out = (state_reg != RUN_ST);

   // [RQ7] [RQ8] A/C pair
   pair_shutdown_drive ac_drive (
      .level_sel_i(ctrl_reg[shutdown_pkg::CTRL_AC_LSB +: 2]),
      .inactive_lvl_i({polarity_i[2], polarity_i[0]}),
      .deadband_done_i(db_done),
      .norm_data_i({norm_data_i[2], norm_data_i[0]}),
      .shut_i(shut_out),
      .data_o(ac_data),
      .oe_o(ac_oe)
   );

   // [RQ6] [RQ8] B/D pair
   pair_shutdown_drive bd_drive (
      .level_sel_i(ctrl_reg[shutdown_pkg::CTRL_BD_LSB +: 2]),
      .inactive_lvl_i({polarity_i[3], polarity_i[1]}),
      .deadband_done_i(db_done),
      .norm_data_i({norm_data_i[3], norm_data_i[1]}),
      .shut_i(shut_out),
      .data_o(bd_data),
      .oe_o(bd_oe)
   );

   always_comb begin
      pins_next.data = {bd_data[1], ac_data[1], bd_data[0], ac_data[0]};
      pins_next.oe = {bd_oe[1], ac_oe[1], bd_oe[0], ac_oe[0]};
   end

   // Remaining registers, interrupt and read data
   always_comb begin
      src_en_next = src_en_reg;
      int_mask_next = int_mask_reg;
      deadband_next = deadband_reg;
      int_status_next = int_status_reg;
      rdata_next = 8'h00;
      if (reg_wr_i) begin
         case (reg_addr_i)
            shutdown_pkg::SRC_EN_OFFS: src_en_next = reg_wdata_i[4:0];
            shutdown_pkg::INT_MASK_OFFS: int_mask_next = reg_wdata_i[1:0];
            shutdown_pkg::DEADBAND_OFFS: deadband_next = reg_wdata_i[5:0];
            shutdown_pkg::INT_STATUS_OFFS: int_status_next = int_status_reg & ~reg_wdata_i[1:0];
            default: ;
         endcase
      end
      // Set wins over a same-cycle clear
      if (state_reg != SHUT_ST && state_next == SHUT_ST) begin
         int_status_next[shutdown_pkg::INT_SHUTDOWN_BIT] = 1'b1;
      end
      if (state_reg == WAIT_EDGE_ST && state_next == RUN_ST) begin
         int_status_next[shutdown_pkg::INT_RESTART_BIT] = 1'b1;
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            shutdown_pkg::CTRL_OFFS: rdata_next = ctrl_reg & shutdown_pkg::CTRL_READ_MASK;
            // [RQ13] Upper enable bits read zero
            shutdown_pkg::SRC_EN_OFFS: rdata_next = {3'h0, src_en_reg} & shutdown_pkg::SRC_EN_READ_MASK;
            shutdown_pkg::INT_STATUS_OFFS: rdata_next = {6'h00, int_status_reg};
            shutdown_pkg::INT_MASK_OFFS: rdata_next = {6'h00, int_mask_reg};
            shutdown_pkg::DEADBAND_OFFS: rdata_next = {2'h0, deadband_reg};
            default: rdata_next = 8'h00;
         endcase
      end
      irq_next = |(int_status_next & int_mask_next);
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         src_en_reg <= shutdown_pkg::SRC_EN_RESET[4:0];
         int_mask_reg <= shutdown_pkg::INT_RESET;
         int_status_reg <= shutdown_pkg::INT_RESET;
         deadband_reg <= shutdown_pkg::DEADBAND_RESET;
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
         pins_reg <= '0;
      end else begin
         src_en_reg <= src_en_next;
         int_mask_reg <= int_mask_next;
         int_status_reg <= int_status_next;
         deadband_reg <= deadband_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         pins_reg <= pins_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign irq_o = irq_reg;
   assign pins_o = pins_reg;
endmodule

// ==== tb/gate_driver_model.sv ====
// Model of the gate drivers fed by the four output pins.
// Assumes pins change on the block's clock.
`timescale 1ns/1ps
module gate_driver_model (
   // Clock
   input wire logic clk_i,
   // Pins from the block
   input wire shutdown_pkg::out_pins_t pins_i,
   // Level each driver sees
   output logic [3:0] seen_o
);
   logic [3:0] last_reg = 4'h0;
   always_ff @(posedge clk_i) begin
      last_reg <= seen_o;
   end
   // Released input wanders, so a stale level never passes
   always_comb begin
      seen_o = (pins_i.data & pins_i.oe) | (~last_reg & ~pins_i.oe);
   end
endmodule

// ==== tb/shutdown_assertions.sv ====
// Checker for the waveform auto-shutdown block, bound to its ports.
// Assumes one clock, asynchronous active-high reset.
`timescale 1ns/1ps
module shutdown_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Sources and generator side
   input wire shutdown_pkg::shutdown_src_t src_i,
   input wire logic wave_in_i,
   input wire logic [3:0] norm_data_i,
   input wire logic [3:0] polarity_i,
   // Outputs
   input wire shutdown_pkg::out_pins_t pins_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic cw;
   assign cw = reg_wr_i && reg_addr_i == shutdown_pkg::CTRL_OFFS && reg_wdata_i[7];
   a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data not zero outside answer");
   a_ctrl_low_bits: assert property (
      reg_rd_i && reg_addr_i == shutdown_pkg::CTRL_OFFS |=> reg_rdata_o[1:0] == 2'h0)
      else $error("control low bits not zero");
   a_src_en_readback: assert property (
      reg_wr_i && reg_addr_i == shutdown_pkg::SRC_EN_OFFS ##2
      reg_rd_i && reg_addr_i == shutdown_pkg::SRC_EN_OFFS
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h1F))
      else $error("source enable readback wrong");
   a_force_high: assert property (cw && reg_wdata_i[5:2] == 4'hF |-> ##2 pins_o == 8'hFF)
      else $error("forced high levels missing");
   a_force_low: assert property (cw && reg_wdata_i[5:2] == 4'hA |-> ##2 pins_o == 8'h0F)
      else $error("forced low levels missing");
   a_force_float: assert property (cw && reg_wdata_i[5:2] == 4'h5 |-> ##2 pins_o.oe == 4'h0)
      else $error("forced release missing");
   a_hold_until_edge: assert property (
      reg_wr_i && reg_addr_i == shutdown_pkg::CTRL_OFFS && !reg_wdata_i[7]
      && pins_o.oe == 4'h0 && !wave_in_i ##1 (!wave_in_i)[*4] |-> pins_o.oe == 4'h0)
      else $error("pins left shutdown before input edge");
   a_irq_masked: assert property (
      reg_wr_i && reg_addr_i == shutdown_pkg::INT_MASK_OFFS && reg_wdata_i == 8'h00
      |-> ##2 !irq_o)
      else $error("interrupt high while masked");
endmodule

bind waveform_auto_shutdown shutdown_checker i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_i(src_i), .wave_in_i(wave_in_i),
   .norm_data_i(norm_data_i), .polarity_i(polarity_i), .pins_o(pins_o), .irq_o(irq_o));

// ==== tb/tb.sv ====
// Self-checking bench for the waveform auto-shutdown block.
// Assumes the checker is bound and the gate driver model sees the pins.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
   logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, wave_in_i, irq_o;
   logic [3:0] reg_addr_i, norm_data_i, polarity_i, seen;
   logic [7:0] reg_wdata_i, reg_rdata_o, d;
   shutdown_pkg::shutdown_src_t src_i;
   shutdown_pkg::out_pins_t pins_o;
   int err_count = 0;
   int tests_run = 0;
   waveform_auto_shutdown i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .src_i(src_i), .wave_in_i(wave_in_i),
      .norm_data_i(norm_data_i), .polarity_i(polarity_i), .pins_o(pins_o), .irq_o(irq_o));
   gate_driver_model i_drv (.clk_i(clk_i), .pins_i(pins_o), .seen_o(seen));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
      @(posedge clk_i) reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_i) reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pulse_wave();
      @(posedge clk_i) wave_in_i <= 1'b1;
      cyc(8);
      @(posedge clk_i) wave_in_i <= 1'b0;
      cyc(8);
   endtask
   task automatic t_reset_values();
      rd(shutdown_pkg::CTRL_OFFS);
      `CHK(d, shutdown_pkg::CTRL_RESET)
      wr(4'hF, 8'hFF);
      rd(4'hF);
      `CHK(d, 8'h00)
      wr(shutdown_pkg::CTRL_OFFS, 8'h7F);
      rd(shutdown_pkg::CTRL_OFFS);
      `CHK(d, 8'h7C)
      wr(shutdown_pkg::SRC_EN_OFFS, 8'hFF);
      rd(shutdown_pkg::SRC_EN_OFFS);
      `CHK(d, 8'h1F)
      wr(shutdown_pkg::SRC_EN_OFFS, 8'h00);
      wr(shutdown_pkg::CTRL_OFFS, 8'h14);
   endtask
   task automatic t_force_levels();
      logic [1:0] f;
      logic [3:0] ed, eo;
      wr(shutdown_pkg::DEADBAND_OFFS, 8'h05);
      for (int k = 0; k < 4; k++) begin
         f = 2'(3 - k);
         ed = (f == 2'h3) ? 4'hF : (f == 2'h2) ? 4'h0 : polarity_i;
         eo = (f == 2'h1) ? 4'h0 : 4'hF;
         wr(shutdown_pkg::CTRL_OFFS, {2'b10, f, f, 2'b00});
         cyc(12);
         `CHK(pins_o.oe, eo)
         if (f == 2'h0) `CHK(seen, polarity_i)
         else if (f != 2'h1) `CHK(seen, ed)
         rd(shutdown_pkg::CTRL_OFFS);
         `CHK(d[7], 1'b1)
         wr(shutdown_pkg::CTRL_OFFS, {2'b00, f, f, 2'b00});
         cyc(6);
         `CHK(pins_o.oe, eo)
         rd(shutdown_pkg::CTRL_OFFS);
         `CHK(d[7], 1'b0)
         pulse_wave();
         `CHK(pins_o, {norm_data_i, 4'hF})
      end
   endtask
   task automatic t_sources();
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_i) src_i <= shutdown_pkg::shutdown_src_t'(5'h01 << i);
         cyc(8);
         rd(shutdown_pkg::CTRL_OFFS);
         `CHK(d[7], 1'b0)
         wr(shutdown_pkg::SRC_EN_OFFS, 8'h01 << i);
         cyc(8);
         rd(shutdown_pkg::CTRL_OFFS);
         `CHK(d[7], 1'b1)
         @(posedge clk_i) src_i <= '0;
         cyc(8);
         rd(shutdown_pkg::CTRL_OFFS);
         `CHK(d[7], 1'b1)
         wr(shutdown_pkg::CTRL_OFFS, 8'h14);
         pulse_wave();
         wr(shutdown_pkg::SRC_EN_OFFS, 8'h00);
      end
      wr(shutdown_pkg::SRC_EN_OFFS, 8'h01);
      wr(shutdown_pkg::CTRL_OFFS, 8'h54);
      @(posedge clk_i) src_i <= 5'h01;
      cyc(8);
      rd(shutdown_pkg::CTRL_OFFS);
      `CHK(d[7], 1'b1)
      @(posedge clk_i) src_i <= '0;
      cyc(8);
      rd(shutdown_pkg::CTRL_OFFS);
      `CHK(d[7], 1'b0)
      pulse_wave();
      wr(shutdown_pkg::SRC_EN_OFFS, 8'h00);
   endtask
   task automatic t_irq();
      wr(shutdown_pkg::INT_STATUS_OFFS, 8'h03);
      wr(shutdown_pkg::INT_MASK_OFFS, 8'h01);
      cyc(3);
      `CHK(irq_o, 1'b0)
      wr(shutdown_pkg::CTRL_OFFS, 8'h94);
      cyc(6);
      `CHK(irq_o, 1'b1)
      wr(shutdown_pkg::INT_MASK_OFFS, 8'h00);
      cyc(3);
      `CHK(irq_o, 1'b0)
      wr(shutdown_pkg::INT_MASK_OFFS, 8'h01);
      wr(shutdown_pkg::INT_STATUS_OFFS, 8'h01);
      cyc(3);
      `CHK(irq_o, 1'b0)
   endtask
   task automatic summarize();
      if (err_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      summarize();
   end
   initial begin
      {sys_rst_i, reg_wr_i, reg_rd_i, wave_in_i} = 4'h8;
      {reg_addr_i, reg_wdata_i, src_i} = '0;
      {norm_data_i, polarity_i} = 8'h69;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_reset_values();
      t_force_levels();
      t_sources();
      t_irq();
      summarize();
   end
endmodule
